// ---- rtl/nvm_regs.vh ----
/*
 Constants for the two-wire nonvolatile memory slave.
 Assumes inclusion by bare name from design files under rtl/.
*/
`ifndef NVM_REGS_VH
`define NVM_REGS_VH
// ----------------------------------------
// Array and address
// ----------------------------------------
`define NVM_DEPTH 8192
`define NVM_AW 13
`define NVM_ADDR_TOP 13'h1fff
`define NVM_ADDR_RST 13'h0000
// ----------------------------------------
// Device address byte fields
// ----------------------------------------
`define NVM_TYPE_MSB 7
`define NVM_TYPE_LSB 4
`define NVM_SEL_MSB 3
`define NVM_SEL_LSB 1
`define NVM_RW_BIT 0
// Device type code, arbitrary value
`define NVM_TYPE_CODE 4'h5
// ----------------------------------------
// Protocol states and counts
// ----------------------------------------
`define NVM_ST_IDLE 3'h0
`define NVM_ST_DEV 3'h1
`define NVM_ST_AHI 3'h2
`define NVM_ST_ALO 3'h3
`define NVM_ST_WDAT 3'h4
`define NVM_ST_RDAT 3'h5
`define NVM_BITS_LAST 3'h7
`endif

// ---- rtl/nvm_array.v ----
/*
 Byte memory array of the two-wire memory slave, 8192 x 8.
 Assumes one write strobe and one read address from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nvm_regs.vh"
module nvm_array (
  // Clock
  input wire clk,
  input wire ce,
  // Port
  input wire we,
  input wire [12:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:`NVM_DEPTH-1];

  // Synchronous write, registered read
  always @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/nvm_slave.v ----
/*
 Two-wire serial memory slave: bus protocol engine and address latch.
 Assumes SCL and SDA come from a master off-chip; both are synchronised
 to CLK, which must run well above the serial clock.
*/
// Function
// [R01] Master alone drives the serial clock
// [R02] Respond only when select pins match
// [R03] Select pins default low when floating
// [R04] Shift out after fall, sample on rise
// [R05] Data line driven low only
// [R06] Write protect pin blocks all writes
// [R07] Array of 8192 bytes
// [R08] 16-bit address, lower 13 bits used
// [R09] Master sends upper address bits zero
// [R10] Write done before next transaction
// [R11] Byte committed right after transfer
// [R12] Recognise start, stop, bit, acknowledge
// [R13] Works up to 1 MHz serial clock
// [R14] Start aborts and readies new operation
// [R15] Stop aborts operation in progress
// [R16] Ninth bit acknowledge; nack ends operation
// [R17] Address increments before ack, wraps; writes increment on the rising SCL edge of the ack bit
// [R18] Unselected or aborted: release, ignore
`timescale 1ns/1ps
`default_nettype none
`include "nvm_regs.vh"
module nvm_slave (
  // Clock and reset
  input wire CLK,
  input wire CE,
  input wire SYS_RST,
  // Two-wire bus
  input wire SCL_I,
  input wire SDA_I,
  output reg SDA_O,
  output reg SDA_OE_N,
  // Straps
  input wire [2:0] DEV_SEL,
  input wire WP
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [1:0] scl_s_q;
  reg [1:0] sda_s_q;
  reg [1:0] sel0_s_q, sel1_s_q, sel2_s_q, wp_s_q;
  reg scl_p_q, sda_p_q;
  wire scl_rise = scl_s_q[1] & ~scl_p_q;
  wire scl_fall = ~scl_s_q[1] & scl_p_q;
  // [R12] start and stop detect
  wire start_det = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
  wire stop_det = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];

  // Two flops on every pin, then one history stage on SCL and SDA only
  // [R03] straps settle low
  // [R13] oversampled serial clock
  always @(posedge CLK) begin
    if (SYS_RST) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      sel0_s_q <= 2'h0;
      sel1_s_q <= 2'h0;
      sel2_s_q <= 2'h0;
      wp_s_q <= 2'h0;
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else if (CE) begin
      scl_s_q <= {scl_s_q[0], SCL_I};
      sda_s_q <= {sda_s_q[0], SDA_I};
      sel0_s_q <= {sel0_s_q[0], DEV_SEL[0]};
      sel1_s_q <= {sel1_s_q[0], DEV_SEL[1]};
      sel2_s_q <= {sel2_s_q[0], DEV_SEL[2]};
      wp_s_q <= {wp_s_q[0], WP};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  wire [2:0] sel = {sel2_s_q[1], sel1_s_q[1], sel0_s_q[1]};
  wire wp = wp_s_q[1];

  // ----------------------------------------
  // Protocol state
  // ----------------------------------------
  localparam PH_DATA = 1'b0;
  localparam PH_ACK = 1'b1;
  reg [2:0] st_q;
  reg ph_q;
  reg [2:0] cnt_q;
  reg [7:0] sh_q;
  reg [12:0] addr_q;
  reg [4:0] ahi_q;
  reg ack_q;
  reg we_q;
  reg [7:0] wd_q;
  reg load_q;
  wire [7:0] rd_byte;
  wire [7:0] rx = {sh_q[6:0], sda_s_q[1]};

  // Address plus one with wrap at the top
  function [12:0] addr_inc;
    input [12:0] a;
    begin
      addr_inc = (a == `NVM_ADDR_TOP) ? `NVM_ADDR_RST : a + 13'h0001;
    end
  endfunction

  // [R07] memory array
  nvm_array u_array (
    .clk(CLK),
    .ce(CE),
    .we(we_q),
    .addr(addr_q),
    .wdata(wd_q),
    .rdata(rd_byte)
  );

  // Main sequencer
  always @(posedge CLK) begin
    if (SYS_RST) begin
      st_q <= `NVM_ST_IDLE;
      ph_q <= PH_DATA;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      addr_q <= `NVM_ADDR_RST;
      ahi_q <= 5'h00;
      ack_q <= 1'b0;
      we_q <= 1'b0;
      wd_q <= 8'h00;
      load_q <= 1'b0;
      SDA_O <= 1'b0;
      SDA_OE_N <= 1'b1;
    end else if (CE) begin
      we_q <= 1'b0;
      load_q <= 1'b0;
      if (load_q) begin
        sh_q <= rd_byte;
      end
      if (start_det) begin
        // [R14] start aborts, expect device address
        st_q <= `NVM_ST_DEV;
        ph_q <= PH_DATA;
        cnt_q <= 3'h0;
        SDA_OE_N <= 1'b1;
      end else if (stop_det) begin
        // [R15] stop aborts
        st_q <= `NVM_ST_IDLE;
        SDA_OE_N <= 1'b1;
      end else if (st_q != `NVM_ST_IDLE) begin
        if (scl_rise) begin
          // [R04] sample on rising edge
          if (ph_q == PH_DATA) begin
            if (st_q != `NVM_ST_RDAT) begin
              sh_q <= rx;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
            end
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `NVM_BITS_LAST) begin
              ph_q <= PH_ACK;
              ack_q <= 1'b0;
              case (st_q)
                `NVM_ST_DEV: begin
                  // [R02] type and select must match
                  ack_q <= (rx[7:4] == `NVM_TYPE_CODE) && (rx[3:1] == sel);
                end
                `NVM_ST_AHI: begin
                  // [R08] keep only low five bits of high byte
                  ahi_q <= rx[4:0];
                  ack_q <= 1'b1;
                end
                `NVM_ST_ALO: begin
                  addr_q <= {ahi_q, rx};
                  ack_q <= 1'b1;
                end
                `NVM_ST_WDAT: begin
                  // [R06] protected: no write, no ack, no increment
                  if (!wp) begin
                    // [R10] write lands before acknowledge
                    // [R11] commit right after eighth bit
                    we_q <= 1'b1;
                    wd_q <= rx;
                    ack_q <= 1'b1;
                  end
                end
                `NVM_ST_RDAT: begin
                  // [R17] increment before acknowledge
                  addr_q <= addr_inc(addr_q);
                end
                default: begin
                  ack_q <= 1'b0;
                end
              endcase
            end
          end else begin
            // [R16] acknowledge bit
            ph_q <= PH_DATA;
            if (st_q == `NVM_ST_RDAT && sda_s_q[1]) begin
              st_q <= `NVM_ST_IDLE;
            end else if (st_q != `NVM_ST_RDAT && !ack_q) begin
              // [R18] not selected or refused: idle
              st_q <= `NVM_ST_IDLE;
            end else begin
              case (st_q)
                `NVM_ST_DEV: begin
                  st_q <= sh_q[`NVM_RW_BIT] ? `NVM_ST_RDAT : `NVM_ST_AHI;
                  if (sh_q[`NVM_RW_BIT]) begin
                    load_q <= 1'b1;
                  end
                end
                `NVM_ST_AHI: st_q <= `NVM_ST_ALO;
                `NVM_ST_ALO: st_q <= `NVM_ST_WDAT;
                `NVM_ST_WDAT: begin
                  // [R17] wrap at top address
                  addr_q <= addr_inc(addr_q);
                end
                `NVM_ST_RDAT: load_q <= 1'b1;
                default: st_q <= `NVM_ST_IDLE;
              endcase
            end
          end
        end else if (scl_fall) begin
          // [R04] drive after falling edge; [R05] low only
          if (ph_q == PH_ACK) begin
            if (st_q == `NVM_ST_RDAT) begin
              SDA_OE_N <= 1'b1;
            end else begin
              SDA_OE_N <= ~ack_q;
            end
          end else if (st_q == `NVM_ST_RDAT) begin
            SDA_OE_N <= sh_q[7];
          end else begin
            SDA_OE_N <= 1'b1;
          end
        end
      end else begin
        SDA_OE_N <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/nvm_slave_asserts.sv ----
/*
 Checker on the ports of the two-wire memory slave.
 Assumes binding onto nvm_slave, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module nvm_slave_asserts (
  // Clock and reset
  input wire CLK,
  input wire CE,
  input wire SYS_RST,
  // Bus
  input wire SCL_I,
  input wire SDA_I,
  input wire SDA_O,
  input wire SDA_OE_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_low_only: assert property (!SDA_O)
    else $error("data output not low");
  a_turn_low: assert property ($changed(SDA_OE_N) |-> !$past(SCL_I, 2))
    else $error("data turned in clock high");
  a_hold_high: assert property (SCL_I [*6] |-> $stable(SDA_OE_N))
    else $error("data moved in clock high");
  a_ack_bound: assert property ($fell(SDA_OE_N) |-> ##[1:400] SDA_OE_N)
    else $error("data held low too long");
  a_start_rel: assert property ($fell(SDA_I) && SCL_I && $past(SCL_I) |=> SDA_OE_N [*8])
    else $error("driven after start");
  a_stop_rel: assert property ($rose(SDA_I) && SCL_I && $past(SCL_I) |=> SDA_OE_N [*8])
    else $error("driven after stop");
  a_reset_rel: assert property ($fell(SYS_RST) |-> SDA_OE_N [*4])
    else $error("driven after reset");
  a_ce_freeze: assert property (!CE |=> $stable(SDA_OE_N))
    else $error("moved while frozen");
endmodule
bind nvm_slave nvm_slave_asserts u_chk (.CLK(CLK), .CE(CE), .SYS_RST(SYS_RST),
  .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N));
`default_nettype wire

// ---- bench/nvm_master.sv ----
/*
 Two-wire bus master model, 160 ns clock within frames only.
 Assumes a pull-up on data: sda high means released.
*/
`timescale 1ns/1ps
`default_nettype none
module nvm_master (
  // Bus
  output logic scl,
  output logic sda,
  input wire logic sda_in
);
  localparam int Q = 40; // Quarter period
  // Idle bus
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task start;
    begin
      sda = 1'b1;
      #Q scl = 1'b1;
      #Q sda = 1'b0;
      #Q scl = 1'b0;
      #Q;
    end
  endtask
  task stop;
    begin
      sda = 1'b0;
      #Q scl = 1'b1;
      #Q sda = 1'b1;
      #Q;
    end
  endtask
  task bit_w(input logic b);
    begin
      sda = b;
      #Q scl = 1'b1;
      #(2 * Q) scl = 1'b0;
      #Q;
    end
  endtask
  // Released line sampled in clock high
  task bit_r(output logic b);
    begin
      sda = 1'b1;
      #Q scl = 1'b1;
      #Q b = sda_in;
      #Q scl = 1'b0;
      #Q;
    end
  endtask
  // Byte MSB first, then acknowledge slot
  task wr(input logic [7:0] d, output logic ack);
    logic b;
    begin
      for (int i = 7; i >= 0; i--) bit_w(d[i]);
      bit_r(b);
      ack = !b;
    end
  endtask
  // Byte in, master acknowledge or not
  task rd(output logic [7:0] d, input logic ack);
    begin
      for (int i = 7; i >= 0; i--) bit_r(d[i]);
      bit_w(!ack);
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/nvm_slave_tb.sv ----
/*
 Testbench of the two-wire memory slave.
 Assumes the master model and a pull-up on data.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nvm_regs.vh"
module nvm_slave_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wp = 1'b0;
  logic [2:0] sel = 3'h5;
  logic ak;
  logic [7:0] rd;
  wire logic scl;
  wire logic sda_m;
  wire logic sda_o;
  wire logic oe_n;
  wire logic sda_w;
  int n_errors = 0;
  int num_checks = 0;
  // Wired data line
  assign sda_w = oe_n ? sda_m : 1'b0;
  // 200 MHz clock
  always #2.5 clk = !clk;
  nvm_master m (.scl(scl), .sda(sda_m), .sda_in(sda_w));
  nvm_slave dut (.CLK(clk), .CE(ce), .SYS_RST(rst), .SCL_I(scl), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE_N(oe_n), .DEV_SEL(sel), .WP(wp));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        n_errors++;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Compare last acknowledge
  task cak(input logic e);
    chk({7'h0, ak}, {7'h0, e});
  endtask
  // Start and device byte
  task dev(input logic [2:0] s, input logic rw);
    begin
      m.start;
      m.wr({`NVM_TYPE_CODE, s, rw}, ak);
    end
  endtask
  // Select for write and load address
  task set_addr(input logic [7:0] hi, input logic [7:0] lo);
    begin
      dev(3'h5, 1'b0);
      cak(1'b1);
      m.wr(hi, ak);
      cak(1'b1);
      m.wr(lo, ak);
      cak(1'b1);
    end
  endtask
  // Write across the top address, read back
  task t_wrap;
    begin
      set_addr(8'hff, 8'hff);
      m.wr(8'ha5, ak);
      cak(1'b1);
      m.wr(8'h3c, ak);
      cak(1'b1);
      m.stop;
      set_addr(8'h1f, 8'hff);
      dev(3'h5, 1'b1);
      cak(1'b1);
      m.rd(rd, 1'b1);
      chk(rd, 8'ha5);
      m.rd(rd, 1'b0);
      chk(rd, 8'h3c);
      m.stop;
    end
  endtask
  // Foreign select and type codes
  task t_unsel;
    begin
      dev(3'h2, 1'b0);
      cak(1'b0);
      m.start;
      m.wr(8'h0a, ak);
      cak(1'b0);
      m.stop;
      sel = 3'h0;
      dev(3'h0, 1'b0);
      cak(1'b1);
      m.stop;
      sel = 3'h5;
    end
  endtask
  // Protected write, then aborted write
  task t_prot;
    begin
      set_addr(8'h00, 8'h10);
      m.wr(8'h11, ak);
      m.stop;
      wp = 1'b1;
      set_addr(8'h00, 8'h10);
      m.wr(8'h77, ak);
      cak(1'b0);
      m.stop;
      wp = 1'b0;
      dev(3'h5, 1'b1);
      m.rd(rd, 1'b0);
      chk(rd, 8'h11);
      m.stop;
      set_addr(8'h00, 8'h10);
      for (int i = 0; i < 4; i++) m.bit_w(1'b0);
      m.stop;
      dev(3'h5, 1'b1);
      m.rd(rd, 1'b0);
      chk(rd, 8'h11);
      m.stop;
    end
  endtask
  task wrap_up;
    begin
      if (n_errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // Reset, freeze, scenarios
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h0, oe_n}, 8'h01);
    ce = 1'b0;
    repeat (3) @(negedge clk);
    ce = 1'b1;
    t_wrap;
    t_unsel;
    t_prot;
    wrap_up;
  end
  // Run limit
  initial begin
    #400000;
    n_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
